// ===== rtl/fcgo_defs.vh
`ifndef FCGO_DEFS_VH
`define FCGO_DEFS_VH
// register subaddresses
`define FCGO_ADDR_CLAMP_START    8'h05
`define FCGO_ADDR_CLAMP_WIDTH    8'h06
`define FCGO_ADDR_HORIZONTAL_SYNC_OUTPUT_WIDTH    8'h07
`define FCGO_ADDR_GAIN_B         8'h08
`define FCGO_ADDR_GAIN_G         8'h09
`define FCGO_ADDR_GAIN_R         8'h0A
`define FCGO_ADDR_OFS_B          8'h0B
`define FCGO_ADDR_OFS_G          8'h0C
`define FCGO_ADDR_OFS_R          8'h0D
`define FCGO_ADDR_CLAMP_CTRL     8'h0F
`define FCGO_ADDR_CLAMP_SEL      8'h10
`define FCGO_ADDR_OFS_LSB        8'h1D
`define FCGO_ADDR_CLAMP_EN       8'h2A
// reset values
`define FCGO_RST_CLAMP_START     8'h32
`define FCGO_RST_CLAMP_WIDTH     8'h20
`define FCGO_RST_HORIZONTAL_SYNC_OUTPUT_WIDTH     8'h20
`define FCGO_RST_GAIN            8'h00
`define FCGO_RST_OFS             8'h80
`define FCGO_RST_CLAMP_CTRL      8'h00
`define FCGO_RST_CLAMP_SEL       8'h00
`define FCGO_RST_OFS_LSB         8'h00
`define FCGO_RST_CLAMP_EN        8'h07
// field positions
`define FCGO_CTRL_SRC_BIT        7
`define FCGO_CTRL_POL_BIT        6
`define FCGO_SEL_R_BIT           0
`define FCGO_SEL_G_BIT           1
`define FCGO_LSB_SEL_B_BIT       6
`define FCGO_LSB_B_HI            5
`define FCGO_LSB_B_LO            4
`define FCGO_LSB_G_HI            3
`define FCGO_LSB_G_LO            2
`define FCGO_LSB_R_HI            1
`define FCGO_LSB_R_LO            0
`define FCGO_EN_R_BIT            0
`define FCGO_EN_G_BIT            1
`define FCGO_EN_B_BIT            2
// datapath constants
`define FCGO_GAIN_UNITY          10'h100
`define FCGO_OFS_ZERO            11'h200
`define FCGO_MID_LEVEL           14'h0200
`define FCGO_CODE_MAX            14'h03FF
`define FCGO_CNT_MAX             9'h1FF
`endif

// ===== rtl/fcgo_fine_clamp_gain_offset.v
// Function
// - internal clamp starts clamp-start pixel clocks after the horizontal sync edge
// - with external timing selected, clamp start is ignored; window follows external pin
// - internal clamp pulse lasts clamp-width pixels, default 32
// - horizontal sync output pulse lasts output-width pixels, default 32
// - per-channel gain is one plus code over 256, unity at zero
// - separate blue, green, red gains act on digitized samples only
// - fine offset is 10 bits: upper byte per channel, two LSBs shared register
// - offset upper byte is offset binary, 80h meaning zero
// - default offset gives blank at 0 bottom-clamped, 512 mid-clamped
// - fine offset added digitally per channel after conversion
// - clamp timing source bit: zero internal window, one external clamp pin
// - per-channel clamp select: bottom or mid level; ignored when clamp disabled
`timescale 1ns/1ps
`default_nettype none
`include "fcgo_defs.vh"

module fcgo_fine_clamp_gain_offset (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // register port from the serial slave
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    output reg  [7:0]  reg_rdata_q,
    // sync and clamp pins
    input  wire        hsync_in,
    input  wire        ext_clamp_in,
    // converted samples, one pixel per clock
    input  wire [9:0]  adc_blue,
    input  wire [9:0]  adc_green,
    input  wire [9:0]  adc_red,
    // timing outputs
    output reg         horizontal_sync_output_q,
    output reg         clamp_window_q,
    output reg  [2:0]  clamp_mid_level_q,
    // processed samples
    output reg  [9:0]  out_blue_q,
    output reg  [9:0]  out_green_q,
    output reg  [9:0]  out_red_q
);

    // registers
    reg [7:0]  clamp_start_delay_q;
    reg [7:0]  clamp_pulse_width_q;
    reg [7:0]  hsync_output_pulse_width_q;
    reg [7:0]  blue_digital_gain_q;
    reg [7:0]  green_digital_gain_q;
    reg [7:0]  red_digital_gain_q;
    reg [7:0]  blue_digital_offset_upper_q;
    reg [7:0]  green_digital_offset_upper_q;
    reg [7:0]  red_digital_offset_upper_q;
    reg [7:0]  clamp_ctrl_q;
    reg [7:0]  clamp_select_q;
    reg [7:0]  offset_lsb_q;
    reg [7:0]  clamp_enable_q;

    // synchronisers
    reg        hs_meta_q;
    reg        hs_sync_q;
    reg        hs_prev_q;
    reg        ext_meta_q;
    reg        ext_sync_q;

    // line timing
    reg [8:0]  pix_cnt_q;
    reg        line_seen_q;

    // sample input stage
    reg [9:0]  smp_b_q;
    reg [9:0]  smp_g_q;
    reg [9:0]  smp_r_q;

    wire       clamp_timing_source;
    wire       hs_edge;
    wire [8:0] clamp_end;
    wire       int_clamp;
    wire       ext_clamp;
    wire       mid_b;
    wire       mid_g;
    wire       mid_r;
    wire [9:0] ofs_b;
    wire [9:0] ofs_g;
    wire [9:0] ofs_r;
    wire [9:0] proc_b;
    wire [9:0] proc_g;
    wire [9:0] proc_r;
    wire       horizontal_sync_output_d;
    wire       clamp_window_d;
    wire [2:0] clamp_mid_level_d;
    reg  [7:0] rd_mux;

    // half-open span test on the pixel count; shared by the sync output and the clamp window
    function in_span;
        input [8:0] cnt;
        input [8:0] first;
        input [8:0] last_ex;
        begin
            in_span = (cnt >= first) && (cnt < last_ex);
        end
    endfunction

    // gain, offset and saturation of one sample
    function [9:0] chan_proc;
        input [9:0] smp;
        input [7:0] gain;
        input [9:0] ofs;
        input       mid;
        reg signed [10:0] x;
        reg signed [10:0] gmul;
        reg signed [21:0] prod;
        reg signed [13:0] sum;
        reg signed [13:0] scaled;
        reg signed [13:0] ofs_s;
        reg signed [13:0] lvl;
        begin
            // mid-clamped samples are centred so gain pivots on blank
            x    = mid ? ($signed({1'b0, smp}) - $signed(`FCGO_OFS_ZERO)) : $signed({1'b0, smp});
            gmul = $signed({1'b0, `FCGO_GAIN_UNITY + {2'b00, gain}});
            prod = x * gmul;
            scaled = prod[21:8];
            ofs_s  = $signed({4'h0, ofs}) - $signed({3'b000, `FCGO_OFS_ZERO});
            lvl    = mid ? `FCGO_MID_LEVEL : 14'h0000;
            sum    = scaled + ofs_s + lvl;
            if (sum < $signed(14'h0000)) begin
                chan_proc = 10'h000;
            end else if (sum > $signed(`FCGO_CODE_MAX)) begin
                chan_proc = 10'h3FF;
            end else begin
                chan_proc = sum[9:0];
            end
        end
    endfunction

    assign clamp_timing_source = clamp_ctrl_q[`FCGO_CTRL_SRC_BIT];
    assign hs_edge             = hs_sync_q & ~hs_prev_q;

    // rules-of-thumb settings for start and width are software's concern; hardware takes any value
    assign clamp_end = {1'b0, clamp_start_delay_q} + {1'b0, clamp_pulse_width_q};
    assign int_clamp = line_seen_q
                     & in_span(pix_cnt_q, {1'b0, clamp_start_delay_q}, clamp_end);
    // polarity bit lets an active-low external pulse open the same window
    assign ext_clamp = ext_sync_q ^ clamp_ctrl_q[`FCGO_CTRL_POL_BIT];

    // select only counts when the channel's fine clamp is on
    assign mid_b = clamp_enable_q[`FCGO_EN_B_BIT] & offset_lsb_q[`FCGO_LSB_SEL_B_BIT];
    assign mid_g = clamp_enable_q[`FCGO_EN_G_BIT] & clamp_select_q[`FCGO_SEL_G_BIT];
    assign mid_r = clamp_enable_q[`FCGO_EN_R_BIT] & clamp_select_q[`FCGO_SEL_R_BIT];

    assign ofs_b = {blue_digital_offset_upper_q,
                    offset_lsb_q[`FCGO_LSB_B_HI:`FCGO_LSB_B_LO]};
    assign ofs_g = {green_digital_offset_upper_q,
                    offset_lsb_q[`FCGO_LSB_G_HI:`FCGO_LSB_G_LO]};
    assign ofs_r = {red_digital_offset_upper_q,
                    offset_lsb_q[`FCGO_LSB_R_HI:`FCGO_LSB_R_LO]};

    // saturation lives inside chan_proc, so a wrapped code can never reach the pins
    assign proc_b = chan_proc(smp_b_q, blue_digital_gain_q, ofs_b, mid_b);
    assign proc_g = chan_proc(smp_g_q, green_digital_gain_q, ofs_g, mid_g);
    assign proc_r = chan_proc(smp_r_q, red_digital_gain_q, ofs_r, mid_r);

    // next values of the timing outputs
    assign horizontal_sync_output_d = line_seen_q
                                    & in_span(pix_cnt_q, 9'h000, {1'b0, hsync_output_pulse_width_q});
    assign clamp_window_d           = clamp_timing_source ? ext_clamp : int_clamp;
    assign clamp_mid_level_d        = {mid_b, mid_g, mid_r};

    // register writes
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clamp_start_delay_q          <= `FCGO_RST_CLAMP_START;
            clamp_pulse_width_q          <= `FCGO_RST_CLAMP_WIDTH;
            hsync_output_pulse_width_q   <= `FCGO_RST_HORIZONTAL_SYNC_OUTPUT_WIDTH;
            blue_digital_gain_q          <= `FCGO_RST_GAIN;
            green_digital_gain_q         <= `FCGO_RST_GAIN;
            red_digital_gain_q           <= `FCGO_RST_GAIN;
            blue_digital_offset_upper_q  <= `FCGO_RST_OFS;
            green_digital_offset_upper_q <= `FCGO_RST_OFS;
            red_digital_offset_upper_q   <= `FCGO_RST_OFS;
            clamp_ctrl_q                 <= `FCGO_RST_CLAMP_CTRL;
            clamp_select_q               <= `FCGO_RST_CLAMP_SEL;
            offset_lsb_q                 <= `FCGO_RST_OFS_LSB;
            clamp_enable_q               <= `FCGO_RST_CLAMP_EN;
        end else if (reg_wr) begin
            case (reg_addr)
                `FCGO_ADDR_CLAMP_START: clamp_start_delay_q          <= reg_wdata;
                `FCGO_ADDR_CLAMP_WIDTH: clamp_pulse_width_q          <= reg_wdata;
                `FCGO_ADDR_HORIZONTAL_SYNC_OUTPUT_WIDTH: hsync_output_pulse_width_q   <= reg_wdata;
                `FCGO_ADDR_GAIN_B:      blue_digital_gain_q          <= reg_wdata;
                `FCGO_ADDR_GAIN_G:      green_digital_gain_q         <= reg_wdata;
                `FCGO_ADDR_GAIN_R:      red_digital_gain_q           <= reg_wdata;
                `FCGO_ADDR_OFS_B:       blue_digital_offset_upper_q  <= reg_wdata;
                `FCGO_ADDR_OFS_G:       green_digital_offset_upper_q <= reg_wdata;
                `FCGO_ADDR_OFS_R:       red_digital_offset_upper_q   <= reg_wdata;
                `FCGO_ADDR_CLAMP_CTRL:  clamp_ctrl_q                 <= reg_wdata;
                `FCGO_ADDR_CLAMP_SEL:   clamp_select_q               <= reg_wdata;
                `FCGO_ADDR_OFS_LSB:     offset_lsb_q                 <= reg_wdata;
                `FCGO_ADDR_CLAMP_EN:    clamp_enable_q               <= reg_wdata;
                default: ;
            endcase
        end
    end

    // readback mux; unmapped subaddresses read zero
    always @* begin
        case (reg_addr)
            `FCGO_ADDR_CLAMP_START: rd_mux = clamp_start_delay_q;
            `FCGO_ADDR_CLAMP_WIDTH: rd_mux = clamp_pulse_width_q;
            `FCGO_ADDR_HORIZONTAL_SYNC_OUTPUT_WIDTH: rd_mux = hsync_output_pulse_width_q;
            `FCGO_ADDR_GAIN_B:      rd_mux = blue_digital_gain_q;
            `FCGO_ADDR_GAIN_G:      rd_mux = green_digital_gain_q;
            `FCGO_ADDR_GAIN_R:      rd_mux = red_digital_gain_q;
            `FCGO_ADDR_OFS_B:       rd_mux = blue_digital_offset_upper_q;
            `FCGO_ADDR_OFS_G:       rd_mux = green_digital_offset_upper_q;
            `FCGO_ADDR_OFS_R:       rd_mux = red_digital_offset_upper_q;
            `FCGO_ADDR_CLAMP_CTRL:  rd_mux = clamp_ctrl_q;
            `FCGO_ADDR_CLAMP_SEL:   rd_mux = clamp_select_q;
            `FCGO_ADDR_OFS_LSB:     rd_mux = offset_lsb_q;
            `FCGO_ADDR_CLAMP_EN:    rd_mux = clamp_enable_q;
            default:                rd_mux = 8'h00;
        endcase
    end

    // readback register, so the port never shows decode glitches
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= rd_mux;
        end
    end

    // pin synchronisers; first stage feeds only the second
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hs_meta_q  <= 1'b0;
            hs_sync_q  <= 1'b0;
            hs_prev_q  <= 1'b0;
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end else begin
            hs_meta_q  <= hsync_in;
            hs_sync_q  <= hs_meta_q;
            hs_prev_q  <= hs_sync_q;
            ext_meta_q <= ext_clamp_in;
            ext_sync_q <= ext_meta_q;
        end
    end

    // pixel counter from the sync leading edge; saturates so long lines cannot retrigger
    // nine bits cover start plus width up to 510, one short of the saturation value
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pix_cnt_q   <= `FCGO_CNT_MAX;
            line_seen_q <= 1'b0;
        end else if (hs_edge) begin
            pix_cnt_q   <= 9'h000;
            line_seen_q <= 1'b1;
        end else if (pix_cnt_q != `FCGO_CNT_MAX) begin
            pix_cnt_q   <= pix_cnt_q + 9'h001;
        end
    end

    // timing outputs
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            horizontal_sync_output_q <= 1'b0;
            clamp_window_q           <= 1'b0;
            clamp_mid_level_q        <= 3'b000;
        end else begin
            horizontal_sync_output_q <= horizontal_sync_output_d;
            clamp_window_q           <= clamp_window_d;
            clamp_mid_level_q        <= clamp_mid_level_d;
        end
    end

    // two-stage datapath: capture, then process
    // the capture stage keeps the multiplier path away from the converter outputs
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            smp_b_q     <= 10'h000;
            smp_g_q     <= 10'h000;
            smp_r_q     <= 10'h000;
            out_blue_q  <= 10'h000;
            out_green_q <= 10'h000;
            out_red_q   <= 10'h000;
        end else begin
            smp_b_q     <= adc_blue;
            smp_g_q     <= adc_green;
            smp_r_q     <= adc_red;
            out_blue_q  <= proc_b;
            out_green_q <= proc_g;
            out_red_q   <= proc_r;
        end
    end

endmodule // fcgo_fine_clamp_gain_offset
`default_nettype wire

// ===== sim/fcgo_props.sv
`timescale 1ns/1ps
`default_nettype none
module fcgo_props (
    // clock, reset, register port
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata_q,
    // sync and clamp
    input wire logic       hsync_in,
    input wire logic       ext_clamp_in,
    input wire logic       horizontal_sync_output_q,
    input wire logic       clamp_window_q
);
    logic [7:0] start_q, width_q, hsw_q;
    logic       src_q, pol_q, hs_pin_q;
    logic [9:0] since_q;
    logic [8:0] hs_n_q, cl_n_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // shadow the timing registers so checks follow what software wrote
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            {start_q, width_q, hsw_q, src_q, pol_q} <= {24'h322020, 2'h0};
            since_q <= 10'h3FF;
            {hs_n_q, cl_n_q} <= 18'h00000;
            hs_pin_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 8'h05) start_q <= reg_wdata;
            if (reg_wr && reg_addr == 8'h06) width_q <= reg_wdata;
            if (reg_wr && reg_addr == 8'h07) hsw_q <= reg_wdata;
            if (reg_wr && reg_addr == 8'h0F) {src_q, pol_q} <= reg_wdata[7:6];
            hs_pin_q <= hsync_in;
            since_q <= (hsync_in && !hs_pin_q) ? 10'h001 : since_q + {9'h000, since_q != 10'h3FF};
            hs_n_q <= horizontal_sync_output_q ? hs_n_q + 9'h001 : 9'h000;
            cl_n_q <= clamp_window_q ? cl_n_q + 9'h001 : 9'h000;
        end
    end
    property p_hs_start; $rose(hsync_in) && hsw_q != 8'h00 |-> ##4 horizontal_sync_output_q; endproperty
    property p_hs_len; $fell(horizontal_sync_output_q) |-> hs_n_q == {1'b0, hsw_q}; endproperty
    property p_hs_zero; hsw_q == 8'h00 && !horizontal_sync_output_q |=> !horizontal_sync_output_q; endproperty
    property p_cl_start; $rose(clamp_window_q) && !src_q |-> since_q == {2'h0, start_q} + 10'h004; endproperty
    property p_cl_len; $fell(clamp_window_q) && !src_q |-> cl_n_q == {1'b0, width_q}; endproperty
    property p_cl_win;
        clamp_window_q && !src_q |-> since_q >= {2'h0, start_q} + 10'h004
            && since_q <= {2'h0, start_q} + {2'h0, width_q} + 10'h003;
    endproperty
    property p_ext;
        (src_q && $stable(ext_clamp_in) && $stable(pol_q))[*4] |-> clamp_window_q == (ext_clamp_in ^ pol_q);
    endproperty
    property p_rd_wr;
        reg_wr && reg_addr inside {[8'h05:8'h0D]} ##1 $stable(reg_addr) && !reg_wr
            |=> reg_rdata_q == $past(reg_wdata, 2);
    endproperty
    a_hs_start: assert property (p_hs_start) else $error("hsync output not started");
    a_hs_len: assert property (p_hs_len) else $error("hsync output width off");
    a_hs_zero: assert property (p_hs_zero) else $error("hsync output at zero width");
    a_cl_start: assert property (p_cl_start) else $error("clamp start off");
    a_cl_len: assert property (p_cl_len) else $error("clamp width off");
    a_cl_win: assert property (p_cl_win) else $error("clamp outside window");
    a_ext: assert property (p_ext) else $error("external clamp not followed");
    a_rd_wr: assert property (p_rd_wr) else $error("register readback off");
    c_int: cover property ($rose(clamp_window_q) && !src_q);
    c_ext: cover property ($rose(clamp_window_q) && src_q);
    c_hs: cover property ($fell(horizontal_sync_output_q));
endmodule // fcgo_props
bind fcgo_fine_clamp_gain_offset fcgo_props fcgo_props_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rdata_q, .hsync_in, .ext_clamp_in, .horizontal_sync_output_q, .clamp_window_q);
`default_nettype wire

// ===== sim/fcgo_vid_src.sv
`timescale 1ns/1ps
`default_nettype none
module fcgo_vid_src (
    // clock and line request
    input  wire logic       clk_sys,
    input  wire logic       sync_go,
    // sync and converted samples
    output var  logic       hsync_in,
    output var  logic [9:0] adc_blue,
    output var  logic [9:0] adc_green,
    output var  logic [9:0] adc_red
);
    logic [2:0] left_q = 3'h0;
    initial begin
        hsync_in = 1'b0;
        {adc_blue, adc_green, adc_red} = 30'h00000000;
    end
    // new samples every pixel, so a stale pipeline stage cannot match by luck
    always @(negedge clk_sys) begin
        adc_blue <= 10'($urandom);
        adc_green <= 10'($urandom);
        adc_red <= 10'($urandom);
        left_q <= sync_go ? 3'h4 : left_q - {2'h0, left_q != 3'h0};
        hsync_in <= sync_go || left_q > 3'h1;
    end
endmodule // fcgo_vid_src
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        ext_clamp_in = 1'b0;
    logic        sync_go = 1'b0;
    logic        chk_en = 1'b0;
    logic        hsync_in, horizontal_sync_output_q, clamp_window_q;
    logic [9:0]  adc_blue, adc_green, adc_red, out_blue_q, out_green_q, out_red_q;
    logic [7:0]  reg_rdata_q;
    logic [2:0]  clamp_mid_level_q, vp = 3'h0;
    logic [7:0]  sh [0:255];
    logic [7:0]  dv [0:8];
    logic [7:0]  rst_v [0:8] = '{8'h32, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
    logic [29:0] ep [0:1];
    int          errors = 0, checks_done = 0, n_cl, n_hs, f_cl;
    always #12.5 clk_sys = ~clk_sys;
    fcgo_fine_clamp_gain_offset fcgo_fine_clamp_gain_offset_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rdata_q, .hsync_in, .ext_clamp_in, .adc_blue, .adc_green, .adc_red, .horizontal_sync_output_q,
        .clamp_window_q, .clamp_mid_level_q, .out_blue_q, .out_green_q, .out_red_q);
    fcgo_vid_src fcgo_vid_src_i (.clk_sys, .sync_go, .hsync_in, .adc_blue, .adc_green, .adc_red);
    task automatic chk(input logic [29:0] got, input logic [29:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        if (a inside {[8'h05:8'h0D], 8'h0F, 8'h10, 8'h1D, 8'h2A}) sh[a] = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        chk(30'(reg_rdata_q), 30'(e), "readback");
    endtask
    // one pixel per channel; mid-clamped channels pivot on the blank level
    function automatic logic [9:0] fexp(input int c, input logic [9:0] s);
        logic m;
        int x, y;
        m = c == 0 ? sh[8'h2A][2] & sh[8'h1D][6] : sh[8'h2A][2 - c] & sh[8'h10][2 - c];
        x = m ? int'(s) - 512 : int'(s);
        y = ((x * (256 + int'(sh[8 + c]))) >>> 8) + int'({sh[11 + c], sh[8'h1D][5 - 2 * c -: 2]}) - 512 + (m ? 512 : 0);
        fexp = y < 0 ? 10'h000 : (y > 1023 ? 10'h3FF : 10'(y));
    endfunction
    always @(posedge clk_sys) begin
        // an input pixel shows on the outputs read at the second edge after it stood
        if (vp[2]) chk({out_blue_q, out_green_q, out_red_q}, ep[1], "pixel");
        ep[0] <= {fexp(0, adc_blue), fexp(1, adc_green), fexp(2, adc_red)};
        ep[1] <= ep[0];
        vp <= {vp[1:0], chk_en};
    end
    task automatic run_line(input logic [7:0] st, input logic [7:0] wd, input logic [7:0] hw);
        wr(8'h05, st);
        wr(8'h06, wd);
        wr(8'h07, hw);
        sync_go <= 1'b1;
        @(negedge clk_sys);
        sync_go <= 1'b0;
        @(posedge clk_sys);
        {n_cl, n_hs, f_cl} = {32'd0, 32'd0, -32'sd1};
        for (int i = 0; i < 600; i++) begin
            @(negedge clk_sys);
            if (clamp_window_q === 1'b1 && f_cl < 0) f_cl = i;
            n_cl += int'(clamp_window_q === 1'b1);
            n_hs += int'(horizontal_sync_output_q === 1'b1);
        end
        chk(30'(n_cl), 30'(wd), "clamp width");
        if (wd != 8'h00) chk(30'(f_cl), 30'(st) + 30'h3, "clamp start");
        chk(30'(n_hs), 30'(hw), "hsync width");
        $display("test line %h %h %h done", st, wd, hw);
    endtask
    initial begin
        void'($urandom(36065));
        for (int a = 0; a < 256; a++) sh[a] = 8'h00;
        for (int j = 0; j < 9; j++) sh[5 + j] = rst_v[j];
        sh[8'h2A] = 8'h07;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        for (int j = 0; j < 9; j++) rd(8'(5 + j), rst_v[j]);
        wr(8'h11, 8'h5A);
        rd(8'h11, 8'h00);
        $display("test reset values done");
        run_line(8'h32, 8'h20, 8'h20);
        run_line(8'h06, 8'h10, 8'h01);
        run_line(8'h00, 8'h01, 8'hFF);
        run_line(8'hFF, 8'hFF, 8'h00);
        repeat (2) run_line(8'($urandom), 8'($urandom), 8'($urandom));
        for (int p = 0; p < 2; p++) begin
            ext_clamp_in = 1'(p);
            wr(8'h0F, {1'b1, 1'(p), 6'h00});
            for (int k = 0; k < 6; k++) begin
                ext_clamp_in = 1'($urandom);
                repeat (5) @(negedge clk_sys);
                chk(30'(clamp_window_q), 30'(ext_clamp_in ^ 1'(p)), "external clamp");
            end
            ext_clamp_in = 1'(p);
            repeat (4) @(negedge clk_sys); // idle level must reach the window before going internal
            wr(8'h0F, 8'h00);
        end
        $display("test external clamp done");
        for (int r = 0; r < 10; r++) begin
            for (int j = 0; j < 9; j++) dv[j] = 8'($urandom);
            if (r == 0) dv = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h07};
            if (r == 1) dv = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h07};
            if (r == 2) dv = '{8'hFF, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h07};
            if (r == 3) dv = '{8'h40, 8'h80, 8'hC0, 8'h80, 8'h81, 8'h7F, 8'h40, 8'h03, 8'h07};
            if (r == 4) dv = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h40, 8'h03, 8'h00};
            dv[6] = dv[6] & 8'h7F;
            dv[7] = dv[7] & 8'h03;
            dv[8] = dv[8] & 8'h07;
            for (int j = 0; j < 9; j++) wr(j < 6 ? 8'(8 + j) : (j == 6 ? 8'h1D : (j == 7 ? 8'h10 : 8'h2A)), dv[j]);
            repeat (4) @(negedge clk_sys);
            chk_en = 1'b1;
            repeat (120) @(negedge clk_sys);
            chk_en = 1'b0;
            chk(30'(clamp_mid_level_q), 30'({sh[8'h2A][2] & sh[8'h1D][6], sh[8'h2A][1:0] & sh[8'h10][1:0]}),
                "mid select");
            for (int j = 0; j < 6; j++) rd(8'(8 + j), dv[j]);
            $display("test datapath round %0d done", r);
        end
        test_done;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        test_done;
    end
endmodule // tb
`default_nettype wire
